// ---- shared/pfo_map.svh ----
// Register offsets, field positions and reset values of the fault stage.
`ifndef PFO_MAP_SVH
`define PFO_MAP_SVH
`define PFO_CTRL     8'h00
`define PFO_FCTRLA   8'h04
`define PFO_FCTRLB   8'h08
`define PFO_DRIVE_CONTROL  8'h0c
`define PFO_EVENT_CONTROL   8'h10
`define PFO_STATUS   8'h14
`define PFO_INTFLAG  8'h18
`define PFO_DTI      8'h1c
`define PFO_PATTERN_SETTING     8'h20
`define PFO_PATTB    8'h24
`define PFO_PER      8'h28
`define PFO_COUNT    8'h2c
`define PFO_CC0      8'h30
`define PFO_CC_LAST  8'h3c
`define PFO_NRV_LSB  8
`define PFO_NRF_LSB  16
`define PFO_LOW_SIDE_DEAD_TIME_LSB 8
`define PFO_HIGH_SIDE_DEAD_TIME_LSB 16
`define PFO_PGV_LSB  8
`define PFO_ST_NRF   2
`define PFO_ST_IDX   3
`define PFO_ST_HALT  4
`define PFO_PER_RST  16'hffff
`endif

// ---- shared/pfo_pkg.sv ----
// Types shared by the fault and output stage.
package pfo_pkg;
  typedef enum logic [1:0] {H_NONE, H_HW, H_SW, H_RSV} pfo_halt_type;
  typedef enum logic [2:0] {
    C_OFF, C_PLAIN_FAULT_CAPTURE, C_MIN, C_MAX, C_LMIN, C_LMAX, C_DERIV, C_RSV
  } pfo_plain_fault_capture_type;
  // Recoverable fault configuration, from bit 11 down to bit 0.
  typedef struct packed {
    logic [3:0]   flen;
    logic         rsv;
    pfo_plain_fault_capture_type plain_fault_capture;
    pfo_halt_type halt;
    logic         restart;
    logic         keep;
  } pfo_fcfg_type;
  // Control word: enable, two-ramp, routing mode.
  typedef struct packed {
    logic [1:0] route;
    logic       two_ramp_mode;
    logic       en;
  } pfo_ctrl_type;
endpackage

// ---- src/pfo_top.sv ----
// Recoverable and non-recoverable fault handling and PWM output stage.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "pfo_map.svh"
// Overview of operation
// - Keep clamps channel to zero during fault.
// - Keep clamp releases at next cycle start.
// - Restart aborts cycle; outputs inactive during fault.
// - Two-ramp restart advances index; faults qualified.
// - Capture mode samples counter on fault.
// - Plain capture stores always, sets flag.
// - Min/max capture keeps extremum, flags updates.
// - Local min/max follow counter, flag conditionally.
// - Extremum notify is OR of both.
// - Hardware halt stalls counter while fault present.
// - Halt on fault A holds channel 0 inactive.
// - Halt plus restart starts fresh cycle after.
// - Software halt needs fault gone and cleared.
// - Non-recoverable fault forces programmed output levels.
// - Non-recoverable filter delays action by cycles.
// - Dead-time slice n drives outputs n, n+half.
// - Routing 0 maps channels modulo channel count.
// - Routing 1,2,3 map half, zero, zero-one.
// - Eight-bit dead-time counter forces both sides off.
// - Rising reloads low-side, falling high-side time.
// - Four dead-time units share one setting.
// - Pattern double buffered, or written directly.
// - Faults A and B come from channel events.
// - Recoverable filter delays, drops short events.
module pfo_top #(
  parameter int CNT_W = 16,
  parameter int OUT_N = 8,
  parameter int CH_N  = 4
) (
  // Clock and synchronous reset.
  input  wire logic              CLK,
  input  wire logic              RST,
  // Register port.
  input  wire logic [7:0]        ADDR,
  input  wire logic [31:0]       WDATA,
  input  wire logic              WR,
  input  wire logic              RD,
  output logic      [31:0]       RDATA,
  // Channel events (faults A, B) and counter events 0, 1.
  input  wire logic [1:0]        MC_EV,
  input  wire logic [1:0]        CNT_EV,
  // Waveform outputs to the port pins.
  output logic      [OUT_N-1:0]  WO
);
  localparam int HALF = OUT_N / 2;
  localparam int DT_N = (CH_N < HALF) ? CH_N : HALF;

  pfo_pkg::pfo_ctrl_type ctrl_q;
  pfo_pkg::pfo_fcfg_type fcfg_q [2];
  logic [7:0]       nre_q, nrv_q, pge_q, pgv_q, pgeb_q, pgvb_q;
  logic [3:0]       nrlen_q;
  logic [1:0]       evnr_q, swst_q, flag_q, fprev_q, hprev_q;
  logic             nrf_q, idx_q, dten_q;
  logic [7:0]       low_side_dead_time_q, high_side_dead_time_q;
  logic [CNT_W-1:0] per_q, cnt_q;
  logic [CNT_W-1:0] cc_q [CH_N];
  logic [3:0]       s1_q, s2_q;
  logic [1:0]       fon, hlt, rsn, cev, cwr, cfl, nrhit;
  logic [CH_N-1:0]  chan;
  logic [OUT_N-1:0] routed, dto, fin;
  logic             wr_st, stall, restart, upd, cyc_start;

  // Pin events cross into the clock domain through two flops.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end
    else
    begin
      s1_q <= {CNT_EV, MC_EV};
      s2_q <= s1_q;
    end
  end

  assign wr_st = WR && ADDR == `PFO_STATUS;

  // Per-fault filtering, qualification, halt and restart decisions.
  for (genvar n = 0; n < 2; n++)
  begin : g_flt
    logic [3:0] fc_q;
    logic       filt, hcond;
    // Counter saturates at the length; a drop before it discards.
    always_ff @(posedge CLK)
    begin
      if (RST)
        fc_q <= 4'h0;
      else if (!s2_q[n])
        fc_q <= 4'h0;
      else if (fc_q != fcfg_q[n].flen)
        fc_q <= fc_q + 4'h1;
    end
    assign filt = s2_q[n] && fc_q == fcfg_q[n].flen;
    // In two-ramp mode fault A counts only in cycle A, B in B.
    assign fon[n] = filt && (!ctrl_q.two_ramp_mode || idx_q == n);
    assign hcond = (fcfg_q[n].halt == pfo_pkg::H_SW) && swst_q[n];
    assign hlt[n] = (fcfg_q[n].halt != pfo_pkg::H_NONE && fon[n])
                    || hcond;
    // Restart on the fault edge, or when a halt lets go.
    assign rsn[n] = fcfg_q[n].restart &&
      ((fcfg_q[n].halt == pfo_pkg::H_NONE) ? (fon[n] && !fprev_q[n])
       : (hprev_q[n] && !hlt[n]));
    assign cev[n] = fon[n] && !fprev_q[n];
  end

  // Sticky per-fault status; a new fault beats a software clear.
  always_ff @(posedge CLK)
  begin
    if (RST)
      swst_q <= 2'b00;
    else
      swst_q <= fon | (swst_q & ~(wr_st ? WDATA[1:0] : 2'b00));
  end

  // Edge history for faults and halts.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      fprev_q <= 2'b00;
      hprev_q <= 2'b00;
    end
    else
    begin
      fprev_q <= fon;
      hprev_q <= hlt;
    end
  end

  assign stall = |hlt;
  assign restart = |rsn;
  assign upd = ctrl_q.en && !stall && !restart && cnt_q >= per_q;
  assign cyc_start = restart || upd;

  // Counter core: restart wins over halt, halt over counting.
  always_ff @(posedge CLK)
  begin
    if (RST)
      cnt_q <= '0;
    else if (restart)
      cnt_q <= '0;
    else if (!ctrl_q.en || stall)
      cnt_q <= cnt_q;
    else if (upd)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 1'b1;
  end

  // Ramp index advances on every new cycle in two-ramp mode.
  always_ff @(posedge CLK)
  begin
    if (RST)
      idx_q <= 1'b0;
    else if (ctrl_q.two_ramp_mode && cyc_start)
      idx_q <= !idx_q;
  end

  // Keep clamp survives the fault until the next cycle begins.
  logic [1:0] keep_q, clamp;
  always_ff @(posedge CLK)
  begin
    if (RST)
      keep_q <= 2'b00;
    else
      for (int n = 0; n < 2; n++)
        if (fcfg_q[n].keep && fon[n])
          keep_q[n] <= 1'b1;
        else if (cyc_start)
          keep_q[n] <= 1'b0;
  end

  for (genvar n = 0; n < 2; n++)
  begin : g_clamp
    assign clamp[n] = (fcfg_q[n].keep && (fon[n] || keep_q[n]))
                      || (fcfg_q[n].restart && fon[n])
                      || hlt[n];
  end

  // Fault capture: decide whether to store and whether to notify.
  for (genvar n = 0; n < 2; n++)
  begin : g_cap
    logic lo, hi;
    assign lo = cnt_q < cc_q[n];
    assign hi = cnt_q > cc_q[n];
    always_comb
    begin
      cwr[n] = 1'b0;
      cfl[n] = 1'b0;
      case (fcfg_q[n].plain_fault_capture)
        pfo_pkg::C_PLAIN_FAULT_CAPTURE:
        begin
          cwr[n] = cev[n];
          cfl[n] = cev[n];
        end
        pfo_pkg::C_MIN:
        begin
          cwr[n] = cev[n] && lo;
          cfl[n] = cev[n] && lo;
        end
        pfo_pkg::C_MAX:
        begin
          cwr[n] = cev[n] && hi;
          cfl[n] = cev[n] && hi;
        end
        pfo_pkg::C_LMIN:
        begin
          cwr[n] = cev[n];
          cfl[n] = cev[n] && lo;
        end
        pfo_pkg::C_LMAX:
        begin
          cwr[n] = cev[n];
          cfl[n] = cev[n] && hi;
        end
        pfo_pkg::C_DERIV:
        begin
          cwr[n] = cev[n];
          cfl[n] = cev[n] && (lo || hi);
        end
        default:
        begin
          cwr[n] = 1'b0;
          cfl[n] = 1'b0;
        end
      endcase
    end
  end

  // Channel registers: a capture beats a software write in one cycle.
  always_ff @(posedge CLK)
  begin
    if (RST)
      for (int k = 0; k < CH_N; k++)
        cc_q[k] <= '0;
    else
      for (int k = 0; k < CH_N; k++)
        if (k < 2 && cwr[k[0]])
          cc_q[k] <= cnt_q;
        else if (WR && ADDR == `PFO_CC0 + 8'(4 * k))
          cc_q[k] <= WDATA[CNT_W-1:0];
  end

  // Match/capture flags; a new capture beats the clear.
  always_ff @(posedge CLK)
  begin
    if (RST)
      flag_q <= 2'b00;
    else
      flag_q <= cfl | (flag_q & ~((WR && ADDR == `PFO_INTFLAG)
                ? WDATA[1:0] : 2'b00));
  end

  // Compare stage; two-ramp mode drops odd channels in A, even in B.
  for (genvar k = 0; k < CH_N; k++)
  begin : g_cmp
    logic on;
    assign on = !ctrl_q.two_ramp_mode || (k % 2) == idx_q;
    if (k < 2)
    begin : g_fc
      assign chan[k] = cnt_q < cc_q[k] && on && !clamp[k];
    end
    else
    begin : g_nf
      assign chan[k] = cnt_q < cc_q[k] && on;
    end
  end

  // Output matrix.
  for (genvar j = 0; j < OUT_N; j++)
  begin : g_rt
    always_comb
    begin
      case (ctrl_q.route)
        2'h0: routed[j] = chan[j % CH_N];
        2'h1: routed[j] = chan[j % (CH_N / 2)];
        2'h2: routed[j] = chan[0];
        default: routed[j] = (j == 0) ? chan[0] : chan[1];
      endcase
    end
  end

  // Dead-time slices; all share one low/high setting.
  for (genvar n = 0; n < HALF; n++)
  begin : g_dt
    if (n < DT_N)
    begin : g_on
      logic [7:0] dtc_q;
      logic [7:0] dt_nx;
      logic       prev_q;
      // The edge cycle already counts as dead time, so neither side can
      // switch in the same cycle as the other one.
      always_comb
      begin
        if (routed[n] != prev_q)
          dt_nx = routed[n] ? low_side_dead_time_q : high_side_dead_time_q;
        else if (dtc_q != 8'h00)
          dt_nx = dtc_q - 8'h01;
        else
          dt_nx = 8'h00;
      end
      always_ff @(posedge CLK)
      begin
        if (RST)
        begin
          dtc_q <= 8'h00;
          prev_q <= 1'b0;
        end
        else
        begin
          prev_q <= routed[n];
          dtc_q <= dt_nx;
        end
      end
      // Both sides off while counting keeps the bridge from shooting.
      assign dto[n] = dten_q ? (routed[n] && dt_nx == 8'h00)
                      : routed[n];
      assign dto[n+HALF] = dten_q ? (!routed[n] && dt_nx == 8'h00)
                           : routed[n+HALF];
    end
    else
    begin : g_off
      assign dto[n] = routed[n];
      assign dto[n+HALF] = routed[n+HALF];
    end
  end

  // Non-recoverable fault inputs, each with its own filter.
  for (genvar m = 0; m < 2; m++)
  begin : g_nr
    logic [3:0] nc_q;
    always_ff @(posedge CLK)
    begin
      if (RST)
        nc_q <= 4'h0;
      else if (!s2_q[m+2] || !evnr_q[m])
        nc_q <= 4'h0;
      else if (nc_q != nrlen_q)
        nc_q <= nc_q + 4'h1;
    end
    assign nrhit[m] = evnr_q[m] && s2_q[m+2] && nc_q == nrlen_q;
  end

  // Non-recoverable state is sticky until software clears it.
  always_ff @(posedge CLK)
  begin
    if (RST)
      nrf_q <= 1'b0;
    else
      nrf_q <= (|nrhit) || (nrf_q && !(wr_st && WDATA[`PFO_ST_NRF]));
  end

  // Final stage: pattern overrides, then forced fault levels.
  for (genvar j = 0; j < OUT_N; j++)
  begin : g_fin
    logic pv;
    assign pv = pge_q[j] ? pgv_q[j] : dto[j];
    assign fin[j] = (nrf_q && nre_q[j]) ? nrv_q[j] : pv;
  end

  // Pins come straight from a register.
  always_ff @(posedge CLK)
  begin
    if (RST)
      WO <= '0;
    else
      WO <= fin;
  end

  // Pattern: buffered copy moves on update, direct write otherwise.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      pge_q <= 8'h00;
      pgv_q <= 8'h00;
      pgeb_q <= 8'h00;
      pgvb_q <= 8'h00;
    end
    else
    begin
      if (WR && ADDR == `PFO_PATTB)
      begin
        pgeb_q <= WDATA[7:0];
        pgvb_q <= WDATA[`PFO_PGV_LSB +: 8];
      end
      if (WR && ADDR == `PFO_PATTERN_SETTING)
      begin
        pge_q <= WDATA[7:0];
        pgv_q <= WDATA[`PFO_PGV_LSB +: 8];
      end
      else if (cyc_start)
      begin
        pge_q <= pgeb_q;
        pgv_q <= pgvb_q;
      end
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ctrl_q <= '0;
      fcfg_q[0] <= '0;
      fcfg_q[1] <= '0;
      {nre_q, nrv_q, nrlen_q} <= '0;
      evnr_q <= 2'b00;
      {dten_q, low_side_dead_time_q, high_side_dead_time_q} <= '0;
      per_q <= `PFO_PER_RST;
    end
    else if (WR)
      case (ADDR)
        `PFO_CTRL: ctrl_q <= WDATA[3:0];
        `PFO_FCTRLA: fcfg_q[0] <= WDATA[11:0];
        `PFO_FCTRLB: fcfg_q[1] <= WDATA[11:0];
        `PFO_DRIVE_CONTROL:
        begin
          nre_q <= WDATA[7:0];
          nrv_q <= WDATA[`PFO_NRV_LSB +: 8];
          nrlen_q <= WDATA[`PFO_NRF_LSB +: 4];
        end
        `PFO_EVENT_CONTROL: evnr_q <= WDATA[1:0];
        `PFO_DTI:
        begin
          dten_q <= WDATA[0];
          low_side_dead_time_q <= WDATA[`PFO_LOW_SIDE_DEAD_TIME_LSB +: 8];
          high_side_dead_time_q <= WDATA[`PFO_HIGH_SIDE_DEAD_TIME_LSB +: 8];
        end
        `PFO_PER: per_q <= WDATA[CNT_W-1:0];
        default: ;
      endcase
  end

  // Read data appear one cycle after the strobe; unmapped reads give 0.
  always_ff @(posedge CLK)
  begin
    if (RST)
      RDATA <= 32'h0;
    else if (!RD)
      RDATA <= 32'h0;
    else
      case (ADDR)
        `PFO_CTRL: RDATA <= 32'(ctrl_q);
        `PFO_FCTRLA: RDATA <= 32'(fcfg_q[0]);
        `PFO_FCTRLB: RDATA <= 32'(fcfg_q[1]);
        `PFO_DRIVE_CONTROL: RDATA <= {12'h0, nrlen_q, nrv_q, nre_q};
        `PFO_EVENT_CONTROL: RDATA <= {30'h0, evnr_q};
        `PFO_STATUS: RDATA <= {27'h0, stall, idx_q, nrf_q, swst_q};
        `PFO_INTFLAG: RDATA <= {30'h0, flag_q};
        `PFO_DTI: RDATA <= {8'h0, high_side_dead_time_q, low_side_dead_time_q, 7'h0, dten_q};
        `PFO_PATTERN_SETTING: RDATA <= {16'h0, pgv_q, pge_q};
        `PFO_PATTB: RDATA <= {16'h0, pgvb_q, pgeb_q};
        `PFO_PER: RDATA <= 32'(per_q);
        `PFO_COUNT: RDATA <= 32'(cnt_q);
        default:
          if (ADDR >= `PFO_CC0 && ADDR <= `PFO_CC_LAST && ADDR[1:0] == 2'b00)
            RDATA <= 32'(cc_q[ADDR[3:2]]);
          else
            RDATA <= 32'h0;
      endcase
  end

  // Checks on the fault and output behaviour.
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  keep_clamp_a: assert property (fcfg_q[0].keep && fon[0] |-> !chan[0])
    else $error("keep did not clamp channel 0");
  keep_hold_a: assert property (keep_q[0] && !cyc_start |=> keep_q[0])
    else $error("keep released before cycle start");
  restart_zero_a: assert property (restart |=> cnt_q == '0)
    else $error("restart did not zero the counter");
  ramp_index_a: assert property (ctrl_q.two_ramp_mode && cyc_start
    |=> idx_q != $past(idx_q)) else $error("ramp index did not advance");
  plain_fault_capture_store_a: assert property (fcfg_q[0].plain_fault_capture == pfo_pkg::C_PLAIN_FAULT_CAPTURE && cev[0]
    |=> cc_q[0] == $past(cnt_q) && flag_q[0]) else $error("capture lost");
  max_keep_a: assert property (fcfg_q[0].plain_fault_capture == pfo_pkg::C_MAX && cev[0]
    && !g_cap[0].hi && !(WR && ADDR == `PFO_CC0) |=> $stable(cc_q[0]))
    else $error("max capture overwrote extremum");
  halt_stall_a: assert property (stall && !restart |=> $stable(cnt_q))
    else $error("counter moved while halted");
  halt_out_a: assert property (hlt[0] |-> !chan[0])
    else $error("channel 0 active while halted");
  nrf_force_a: assert property (nrf_q && nre_q[0] |=> WO[0] == $past(nrv_q[0]))
    else $error("forced level missing");
  dt_reload_a: assert property (routed[0] && !g_dt[0].g_on.prev_q
    |=> g_dt[0].g_on.dtc_q == $past(low_side_dead_time_q)) else $error("dead time reload");

  cov_restart_c: cover property (restart ##1 fon[0]);
  cov_software_halt_c: cover property (hlt[0] && !fon[0] ##1 !hlt[0]);
  cov_nrf_c: cover property (|nrhit);
  cov_deriv_c: cover property (fcfg_q[0].plain_fault_capture == pfo_pkg::C_DERIV && cfl[0]);
endmodule

// ---- tb/pfo_bridge.sv ----
// Behavioural half-bridge load watching the gate drives of four legs.
`timescale 1ns/1ps
module pfo_bridge (
  // Clock and reset of the observer.
  input  wire logic        clk,
  input  wire logic        rst,
  // Gate drives: low switch n at bit n, high switch at bit n+4.
  input  wire logic [7:0]  gate,
  // Last dead span of leg 0 and count of shorted cycles.
  output logic      [7:0]  dead_span_q,
  output logic      [15:0] shoot_q
);
  logic [7:0] run_q;

  // Both switches of one leg on shorts the supply, so count those cycles.
  always_ff @(posedge clk)
  begin
    if (rst)
      shoot_q <= 16'h0000;
    else if (|(gate[3:0] & gate[7:4]))
      shoot_q <= shoot_q + 16'h0001;
  end

  // Time how long leg 0 rests with both switches off.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      run_q       <= 8'h00;
      dead_span_q <= 8'h00;
    end
    else if (!gate[0] && !gate[4])
      run_q <= run_q + 8'h01;
    else
    begin
      if (run_q != 8'h00)
        dead_span_q <= run_q;
      run_q <= 8'h00;
    end
  end
endmodule

// ---- tb/tb_pfo_top.sv ----
// Self-checking bench for the fault and output stage.
`timescale 1ns/1ps
`include "pfo_map.svh"
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("[ERR] %s exp %0h got %0h", nm, e, g); \
    end \
  end
module tb_pfo_top;
  logic        clk;
  logic        rst;
  logic        wr_s;
  logic        rd_s;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [31:0] v;
  logic [31:0] u;
  logic [1:0]  mc_ev;
  logic [1:0]  cnt_ev;
  logic [7:0]  wave;
  logic [7:0]  span;
  logic [15:0] shoot;
  logic [15:0] s0;
  logic [15:0] cc;
  logic        ef;
  logic        idx;
  int          fail_count;
  int          checks_done;
  int          n;
  int          k;

  // Device under test and the bridge it drives.
  pfo_top i_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr_s), .RD(rd_s), .RDATA(rdata), .MC_EV(mc_ev),
    .CNT_EV(cnt_ev), .WO(wave));
  pfo_bridge i_load (.clk(clk), .rst(rst), .gate(wave),
    .dead_span_q(span), .shoot_q(shoot));

  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Bus and stimulus helpers; all drives land right after a rising edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic ck(input string nm, input logic [7:0] a,
                    input logic [31:0] e);
    rd(a, v);
    `CHK(nm, e, v)
  endtask
  task automatic cy(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic fault(input int b, input logic lv);
    @(posedge clk);
    mc_ev[b] <= lv;
  endtask
  task automatic pulse(input int b, input int w);
    fault(b, 1'b1);
    repeat (w - 1) @(posedge clk);
    fault(b, 1'b0);
  endtask
  task automatic ccs(input logic [3:0] c);
    for (int i = 0; i < 4; i++)
      wr(`PFO_CC0 + 8'(4 * i), c[i] ? 32'hffff : 32'h0);
  endtask
  // Waits for the forced level and returns the cycles it took.
  task automatic nrlat(input int b, output int c);
    @(posedge clk);
    cnt_ev[b] <= 1'b1;
    c = 0;
    while (wave !== 8'ha5 && c < 40)
    begin
      @(posedge clk);
      #1;
      c++;
    end
    @(posedge clk);
    cnt_ev[b] <= 1'b0;
  endtask
  task automatic tend(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Expected pin word for a routing mode and four channel levels.
  function automatic logic [7:0] xroute(input int md, input logic [3:0] c);
    for (int x = 0; x < 8; x++)
      xroute[x] = md == 0 ? c[x % 4] : md == 1 ? c[x % 2] :
                  md == 2 ? c[0] : (x == 0 ? c[0] : c[1]);
  endfunction

  // Guards against a hang; the tests need about 6000 cycles.
  initial
  begin
    #500000;
    $display("watchdog expired");
    fail_count++;
    test_done;
  end

  // Main sequence.
  initial
  begin
    rst = 1'b1;
    wr_s = 1'b0;
    rd_s = 1'b0;
    addr = 8'h00;
    wdata = 32'h0;
    mc_ev = 2'b00;
    cnt_ev = 2'b00;
    fail_count = 0;
    checks_done = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    cy(1);
    `CHK("pins", 8'h00, wave)
    ck("period", `PFO_PER, {16'h0, `PFO_PER_RST});
    ck("unmapped", 8'h40, 32'h0);
    wr(`PFO_COUNT, 32'h55);
    ck("count", `PFO_COUNT, 32'h0);
    tend("reset");
    wr(`PFO_PER, 32'h100);
    ccs(4'b0110);
    for (int m = 0; m < 4; m++)
    begin
      wr(`PFO_CTRL, {28'h0, 2'(m), 2'b01});
      cy(4);
      `CHK("route", xroute(m, 4'b0110), wave)
    end
    tend("routing");
    // Direct pattern now, buffered pattern only at the next update.
    wr(`PFO_CTRL, 32'h0);
    wr(`PFO_PATTERN_SETTING, 32'h5aff);
    cy(3);
    `CHK("direct", 8'h5a, wave)
    wr(`PFO_PATTB, 32'hc3ff);
    cy(10);
    `CHK("buffered", 8'h5a, wave)
    wr(`PFO_CTRL, 32'h1);
    cy(270);
    `CHK("update", 8'hc3, wave)
    wr(`PFO_PATTB, 32'h0);
    wr(`PFO_PATTERN_SETTING, 32'h0);
    tend("pattern");
    ccs(4'b0001);
    wr(`PFO_DTI, 32'h050301);
    cy(20);
    s0 = shoot;
    wr(`PFO_CC0, 32'h0);
    cy(20);
    `CHK("off_high", 8'h05, span)
    wr(`PFO_CC0, 32'hffff);
    cy(20);
    `CHK("off_low", 8'h03, span)
    `CHK("pair", 8'he1, wave)
    `CHK("short", s0, shoot)
    wr(`PFO_DTI, 32'h0);
    tend("dead time");
    ccs(4'b1111);
    wr(`PFO_PER, 32'h400);
    for (int f = 0; f < 2; f++)
    begin
      wr(f ? `PFO_FCTRLB : `PFO_FCTRLA, 32'h401);
      pulse(f, 3);
      cy(10);
      `CHK("glitch", 8'hff, wave)
      fault(f, 1'b1);
      cy(8);
      `CHK("keep", 8'hff ^ (8'h11 << f), wave)
      fault(f, 1'b0);
      cy(4);
      `CHK("held", 8'hff ^ (8'h11 << f), wave)
      n = 0;
      while (wave !== 8'hff && n < 1100)
      begin
        cy(1);
        n++;
      end
      `CHK("freed", 8'hff, wave)
      wr(f ? `PFO_FCTRLB : `PFO_FCTRLA, 32'h0);
    end
    tend("keep");
    wr(`PFO_PER, 32'h100);
    wr(`PFO_FCTRLA, 32'h4);
    fault(0, 1'b1);
    cy(6);
    rd(`PFO_COUNT, u);
    cy(5);
    ck("halted", `PFO_COUNT, u);
    `CHK("clamp0", 8'hee, wave)
    fault(0, 1'b0);
    cy(6);
    rd(`PFO_COUNT, v);
    `CHK("resumed", 1'b1, v != u)
    wr(`PFO_FCTRLA, 32'h6);
    cy(60);
    pulse(0, 6);
    cy(4);
    rd(`PFO_COUNT, v);
    `CHK("fresh", 1'b1, v < 32'h10)
    wr(`PFO_FCTRLA, 32'h2);
    cy(60);
    fault(0, 1'b1);
    cy(8);
    `CHK("inactive", 8'hee, wave)
    rd(`PFO_COUNT, v);
    `CHK("restart", 1'b1, v < 32'h10)
    fault(0, 1'b0);
    wr(`PFO_STATUS, 32'h7);
    wr(`PFO_FCTRLA, 32'h8);
    pulse(0, 6);
    cy(6);
    rd(`PFO_COUNT, u);
    cy(5);
    ck("sw_halt", `PFO_COUNT, u);
    wr(`PFO_STATUS, 32'h1);
    cy(3);
    rd(`PFO_COUNT, v);
    `CHK("sw_free", 1'b1, v != u)
    tend("halt");
    wr(`PFO_FCTRLA, 32'h2);
    wr(`PFO_FCTRLB, 32'h2);
    wr(`PFO_CTRL, 32'h3);
    cy(20);
    rd(`PFO_STATUS, v);
    idx = v[`PFO_ST_IDX];
    for (int j = 0; j < 2; j++)
    begin
      pulse(int'(idx), 4);
      cy(4);
      rd(`PFO_STATUS, v);
      `CHK("ramp_idx", ~idx, v[`PFO_ST_IDX])
    end
    wr(`PFO_CTRL, 32'h1);
    wr(`PFO_FCTRLB, 32'h0);
    tend("two ramp");
    // Capture modes, each against a reference of the kept value and flag.
    for (int md = 1; md < 7; md++)
    begin
      cc = (md == 2 || md == 4) ? 16'hffff :
           (md == 3 || md == 5) ? 16'h0000 : 16'h0080;
      wr(`PFO_FCTRLA, 32'h0);
      wr(`PFO_CC0, {16'h0, cc});
      wr(`PFO_FCTRLA, 32'(md) << 4);
      for (int j = 0; j < 4; j++)
      begin
        wr(`PFO_CTRL, 32'h1);
        cy(100);
        wr(`PFO_CTRL, 32'h0);
        rd(`PFO_COUNT, u);
        pulse(0, 3);
        cy(6);
        case (md)
          1: ef = 1'b1;
          2, 4: ef = u[15:0] < cc;
          3, 5: ef = u[15:0] > cc;
          default: ef = u[15:0] != cc;
        endcase
        if ((md != 2 && md != 3) || ef)
          cc = u[15:0];
        ck("capture", `PFO_CC0, {16'h0, cc});
        rd(`PFO_INTFLAG, v);
        `CHK("flag", ef, v[0])
        wr(`PFO_INTFLAG, 32'h3);
      end
    end
    wr(`PFO_FCTRLA, 32'h0);
    tend("capture");
    ccs(4'b0000);
    wr(`PFO_CTRL, 32'h1);
    wr(`PFO_DRIVE_CONTROL, 32'ha5ff);
    wr(`PFO_EVENT_CONTROL, 32'h1);
    nrlat(0, n);
    `CHK("forced", 8'ha5, wave)
    cy(5);
    `CHK("sticky", 8'ha5, wave)
    wr(`PFO_STATUS, 32'h4);
    cy(4);
    `CHK("cleared", 8'h00, wave)
    wr(`PFO_DRIVE_CONTROL, 32'h3a5ff);
    wr(`PFO_EVENT_CONTROL, 32'h2);
    nrlat(1, k);
    `CHK("filtered", n + 3, k)
    wr(`PFO_STATUS, 32'h4);
    tend("forcing");
    test_done;
  end
endmodule
